// ==== core/receiver_status_snapshot_regs.sv ====
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
// Operation
// R1: Threshold bits 11:8 in high register low nibble
// R2: Threshold bits 7:0 in byte below
// R3: Threshold changes apply only after soft reset
// R4: Update bit write one captures all status
// R5: Update bit clears only after capture completes
// R6: Host polls update bit zero before reading
// R7: Status bit 3 flags segment errors over threshold
// R8: Status bit 1 flags slicer error over threshold
// R9: Status bit 0 shows field sync locked
// R10: Gain accumulator split over three read registers
// R11: Accumulator bits 19:16 low nibble, upper zero
// R12: Accumulator registers change only on update
// R13: Detect bit 0 shows co-channel analog TV
// R14: Reserved bits read zero, ignore writes
// R15: Segment errors counted per interval vs threshold
module receiver_status_snapshot_regs
	import rx_status_pkg::*;
#(
	parameter logic [23:0] INTERVAL_BLOCKS = INTERVAL_BLOCKS_RST
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rx_status_pkg::ADDR_W-1:0] paddr,
	input wire logic [rx_status_pkg::DATA_W-1:0] pwdata,
	output logic [rx_status_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rs_block_strobe,
	input wire logic seg_err_pulse,
	input wire logic slicer_err_over_threshold,
	input wire logic field_sync_locked,
	input wire logic [rx_status_pkg::GAIN_ACC_W-1:0] gain_acc,
	input wire logic cochannel_tv_detected,
	output logic soft_reset_out,
	output logic irq
);

	import rx_status_pkg::*;

	// Software-visible state
	logic [7:0] seg_err_threshold_lo_reg;
	logic [3:0] seg_err_threshold_hi_reg;
	logic [THR_W-1:0] thr_active_reg;
	logic update_reg;
	logic [EV_W-1:0] irq_status_reg;
	logic [EV_W-1:0] irq_status_next;
	logic [EV_W-1:0] irq_mask_reg;

	// Snapshot of the status registers
	logic seg_err_over_threshold;
	logic slicer_snap_reg;
	logic fsync_snap_reg;
	logic seg_snap_reg;
	logic [GAIN_ACC_W-1:0] acc_snap_reg;
	logic detect_snap_reg;

	// Event detection history
	logic seg_prev_reg;
	logic fsync_prev_reg;

	upd_state_type upd_state_reg;
	upd_state_type upd_state_next;

	// Bus phase decoding; one wait state, completion when pready is seen high
	wire logic access_phase = psel && penable && !pready;
	wire logic xfer_done = psel && penable && pready;
	wire logic wr_done = xfer_done && pwrite;
	wire logic rd_done = xfer_done && !pwrite;

	// Address decoding
	wire logic hit_soft = paddr == byte_addr(IDX_SOFT_RESET);
	wire logic hit_thr_lo = paddr == byte_addr(IDX_THR_LO);
	wire logic hit_thr_hi = paddr == byte_addr(IDX_THR_HI);
	wire logic hit_update = paddr == byte_addr(IDX_UPDATE);
	wire logic hit_lock = paddr == byte_addr(IDX_LOCK);
	wire logic hit_acc_lo = paddr == byte_addr(IDX_ACC_LO);
	wire logic hit_acc_mid = paddr == byte_addr(IDX_ACC_MID);
	wire logic hit_acc_hi = paddr == byte_addr(IDX_ACC_HI);
	wire logic hit_detect = paddr == byte_addr(IDX_DETECT);
	wire logic hit_irq_st = paddr == byte_addr(IDX_IRQ_STATUS);
	wire logic hit_irq_mask = paddr == byte_addr(IDX_IRQ_MASK);
	wire logic mapped = hit_soft || hit_thr_lo || hit_thr_hi || hit_update || hit_lock ||
		hit_acc_lo || hit_acc_mid || hit_acc_hi || hit_detect || hit_irq_st || hit_irq_mask;

	// Read data selection; every bit not listed reads zero [R14]
	wire logic [DATA_W-1:0] rd_word =
		hit_thr_lo ? {24'h000000, seg_err_threshold_lo_reg} : // [R2]
		hit_thr_hi ? {28'h0000000, seg_err_threshold_hi_reg} : // [R1]
		hit_update ? {31'h00000000, update_reg} : // [R6]
		hit_lock ? {28'h0000000, seg_snap_reg, 1'b0, slicer_snap_reg, fsync_snap_reg} :
		hit_acc_lo ? {24'h000000, acc_snap_reg[7:0]} : // [R10]
		hit_acc_mid ? {24'h000000, acc_snap_reg[15:8]} : // [R10]
		hit_acc_hi ? {28'h0000000, acc_snap_reg[19:16]} : // [R11]
		hit_detect ? {31'h00000000, detect_snap_reg} : // [R13]
		hit_irq_st ? {29'h00000000, irq_status_reg} :
		hit_irq_mask ? {29'h00000000, irq_mask_reg} :
		32'h00000000;

	// Update request decoding
	wire logic upd_write_one = wr_done && hit_update && pwdata[UPDATE_BIT];
	wire logic capture_en = upd_state_reg == UPD_CAPTURE;
	wire logic capture_done = upd_state_reg == UPD_DONE;
	wire logic soft_hit = wr_done && hit_soft;

	// Bus answer: registered so every bus output comes from a flip-flop
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= access_phase;
			prdata <= access_phase && !pwrite ? rd_word : 32'h00000000;
			pslverr <= access_phase && !mapped;
		end
	end

	// Threshold bytes; reserved upper nibble has no storage at all [R14]
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seg_err_threshold_lo_reg <= THR_LO_RST;
			seg_err_threshold_hi_reg <= THR_HI_RST;
			irq_mask_reg <= IRQ_MASK_RST;
		end else if (wr_done) begin
			if (hit_thr_lo) begin
				seg_err_threshold_lo_reg <= pwdata[7:0]; // [R2]
			end
			if (hit_thr_hi) begin
				seg_err_threshold_hi_reg <= pwdata[3:0]; // [R1]
			end
			if (hit_irq_mask) begin
				irq_mask_reg <= pwdata[EV_W-1:0];
			end
		end
	end

	// Soft reset pulse; any write to index zero, data ignored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			soft_reset_out <= 1'b0;
		end else begin
			soft_reset_out <= soft_hit; // [R3]
		end
	end

	// Working threshold only picks up the written bytes on a soft reset
	// This keeps the comparator from seeing a half-written twelve-bit value
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			thr_active_reg <= {THR_HI_RST, THR_LO_RST};
		end else if (soft_reset_out) begin
			thr_active_reg <= {seg_err_threshold_hi_reg, seg_err_threshold_lo_reg}; // [R3]
		end
	end

	// Segment error counting over the configured interval
	seg_err_monitor #(
		.CNT_W(24),
		.INTERVAL_BLOCKS(INTERVAL_BLOCKS)
	) u_seg_err_monitor (
		.ref_clk(ref_clk),
		.rst(rst),
		.soft_reset(soft_reset_out),
		.rs_block_strobe(rs_block_strobe),
		.seg_err_pulse(seg_err_pulse),
		.threshold(thr_active_reg), // [R15]
		.over_threshold(seg_err_over_threshold)
	);

	// Update sequencer: request, one capture cycle, then release the bit
	always_comb begin
		upd_state_next = upd_state_reg;
		case (upd_state_reg)
			UPD_IDLE: begin
				if (upd_write_one) begin
					upd_state_next = UPD_CAPTURE; // [R4]
				end
			end
			UPD_CAPTURE: begin
				upd_state_next = UPD_DONE;
			end
			UPD_DONE: begin
				// A new request landing on the release cycle starts another capture
				upd_state_next = upd_write_one ? UPD_CAPTURE : UPD_IDLE;
			end
			default: begin
				upd_state_next = UPD_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			upd_state_reg <= UPD_IDLE;
		end else begin
			upd_state_reg <= upd_state_next;
		end
	end

	// Update bit: set by software, cleared by hardware after capture; set wins
	// Writing zero cannot cancel a capture already under way
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			update_reg <= 1'b0;
		end else if (upd_write_one) begin
			update_reg <= 1'b1; // [R4]
		end else if (capture_done) begin
			update_reg <= 1'b0; // [R5]
		end
	end

	// Snapshot of every status register, taken together in one cycle
	// Reads between updates stay coherent even while the loops move
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seg_snap_reg <= 1'b0;
			slicer_snap_reg <= 1'b0;
			fsync_snap_reg <= 1'b0;
			acc_snap_reg <= '0;
			detect_snap_reg <= 1'b0;
		end else if (capture_en) begin
			seg_snap_reg <= seg_err_over_threshold; // [R7]
			slicer_snap_reg <= slicer_err_over_threshold; // [R8]
			fsync_snap_reg <= field_sync_locked; // [R9]
			acc_snap_reg <= gain_acc; // [R12]
			detect_snap_reg <= cochannel_tv_detected; // [R13]
		end
	end

	// Edge history for the interrupt events
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seg_prev_reg <= 1'b0;
			fsync_prev_reg <= 1'b0;
		end else begin
			seg_prev_reg <= seg_err_over_threshold;
			fsync_prev_reg <= field_sync_locked;
		end
	end

	// Sticky events; a read of the status word clears it, a new event wins
	wire logic [EV_W-1:0] events = {
		fsync_prev_reg && !field_sync_locked,
		seg_err_over_threshold && !seg_prev_reg,
		capture_done
	};
	// Clear only what the read returned; a bit set after the data was latched stays
	wire logic [EV_W-1:0] status_kept =
		(rd_done && hit_irq_st) ? irq_status_reg & ~prdata[EV_W-1:0] : irq_status_reg;

	always_comb begin
		irq_status_next = status_kept | events;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_status_reg <= '0;
			irq <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			irq <= |(irq_status_next & irq_mask_reg);
		end
	end

	// Checks

	AST_UPDATE_RELEASE: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
		$rose(update_reg) |-> update_reg [*2] ##1 (!update_reg || upd_write_one))
		else $error("update bit not released two cycles after capture start");

	AST_UPDATE_HELD: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
		update_reg && upd_state_reg != UPD_DONE |=> update_reg)
		else $error("update bit dropped before capture finished");

	AST_ACC_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
		!capture_en |=> $stable(acc_snap_reg))
		else $error("gain accumulator snapshot changed without update");

	AST_ACC_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
		upd_write_one && upd_state_reg == UPD_IDLE |=> ##1 acc_snap_reg == $past(gain_acc, 1))
		else $error("gain accumulator not captured after update request");

	AST_LOCK_MAP: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
		capture_en |=> fsync_snap_reg == $past(field_sync_locked)
			&& slicer_snap_reg == $past(slicer_err_over_threshold)
			&& detect_snap_reg == $past(cochannel_tv_detected))
		else $error("status snapshot does not match sampled inputs");

	AST_THR_DEFER: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
		!soft_reset_out |=> $stable(thr_active_reg))
		else $error("working threshold changed without soft reset");

	AST_SOFT_LOAD: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
		soft_hit |=> ##1 thr_active_reg ==
			{$past(seg_err_threshold_hi_reg), $past(seg_err_threshold_lo_reg)})
		else $error("soft reset did not load the threshold");

	AST_HI_RESERVED: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
		access_phase && !pwrite && (hit_thr_hi || hit_acc_hi) |=> pready && prdata[31:4] == 28'h0)
		else $error("reserved bits read nonzero");

	AST_PREADY: assert property (@(posedge ref_clk) disable iff (rst)
		access_phase |=> pready ##1 !pready)
		else $error("bus answer not exactly one cycle after access phase");

	AST_IRQ_STICKY: assert property (@(posedge ref_clk) disable iff (rst)
		capture_done && irq_mask_reg[EV_CAPTURE_DONE] |=> irq && irq_status_reg[EV_CAPTURE_DONE])
		else $error("capture done event did not raise interrupt");

	AST_UPDATE_SET_ONLY: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
		!upd_write_one |=> !$rose(update_reg))
		else $error("update bit set without a write of one");

	AST_SEG_SNAP: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
		capture_en |=> seg_snap_reg == $past(seg_err_over_threshold))
		else $error("segment error snapshot does not match the monitor");

	AST_STATUS_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
		!capture_en |=> $stable(seg_snap_reg) && $stable(slicer_snap_reg)
			&& $stable(fsync_snap_reg) && $stable(detect_snap_reg))
		else $error("status snapshot changed without update");

	AST_THR_HI_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
		wr_done && hit_thr_hi |=> seg_err_threshold_hi_reg == $past(pwdata[3:0]))
		else $error("threshold high nibble not written");

	AST_THR_LO_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
		wr_done && hit_thr_lo |=> seg_err_threshold_lo_reg == $past(pwdata[7:0]))
		else $error("threshold low byte not written");

	AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
		access_phase && !mapped |=> pready && pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");

	AST_SOFT_PULSE: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
		soft_reset_out |=> !soft_reset_out)
		else $error("soft reset pulse longer than one cycle");

	AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
		irq_status_reg == '0 |-> !irq)
		else $error("interrupt high with no status bit set");

endmodule

// ==== shared/rx_status_pkg.sv ====
package rx_status_pkg;

	// Bus geometry: printed offsets are word indices, byte address is four times the index
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// Word indices of the register map
	localparam logic [7:0] IDX_SOFT_RESET = 8'h00;
	localparam logic [7:0] IDX_THR_LO = 8'h21;
	localparam logic [7:0] IDX_THR_HI = 8'h22;
	localparam logic [7:0] IDX_UPDATE = 8'h25;
	localparam logic [7:0] IDX_LOCK = 8'h26;
	localparam logic [7:0] IDX_ACC_LO = 8'h27;
	localparam logic [7:0] IDX_ACC_MID = 8'h28;
	localparam logic [7:0] IDX_ACC_HI = 8'h29;
	localparam logic [7:0] IDX_DETECT = 8'h2A;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h51;

	// Field positions
	localparam int unsigned UPDATE_BIT = 0;
	localparam int unsigned LOCK_SEG_BIT = 3;
	localparam int unsigned LOCK_SLICER_BIT = 1;
	localparam int unsigned LOCK_FSYNC_BIT = 0;
	localparam int unsigned DETECT_BIT = 0;
	localparam int unsigned EV_CAPTURE_DONE = 0;
	localparam int unsigned EV_SEG_ERR_RISE = 1;
	localparam int unsigned EV_SYNC_LOST = 2;
	localparam int unsigned EV_W = 3;

	// Widths and values after reset
	localparam int unsigned GAIN_ACC_W = 20;
	localparam int unsigned THR_W = 12;
	localparam logic [7:0] THR_LO_RST = 8'h05;
	localparam logic [3:0] THR_HI_RST = 4'h0;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic [23:0] INTERVAL_BLOCKS_RST = 24'h0064BC;

	// Cycles from the accepted update write until the bit reads zero
	localparam int unsigned CAPTURE_CYCLES = 2;

	typedef enum logic [1:0] {
		UPD_IDLE,
		UPD_CAPTURE,
		UPD_DONE
	} upd_state_type;

	// Byte address of a word index
	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

endpackage

// ==== core/seg_err_monitor.sv ====
`timescale 1ns/10ps
module seg_err_monitor
	import rx_status_pkg::*;
#(
	parameter int unsigned CNT_W = 24,
	parameter logic [23:0] INTERVAL_BLOCKS = INTERVAL_BLOCKS_RST
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic soft_reset,
	input wire logic rs_block_strobe,
	input wire logic seg_err_pulse,
	input wire logic [THR_W-1:0] threshold,
	output logic over_threshold
);

	logic [CNT_W-1:0] block_cnt_reg;
	logic [CNT_W-1:0] err_cnt_reg;
	wire logic interval_end = rs_block_strobe && (block_cnt_reg + 1'b1 >= CNT_W'(INTERVAL_BLOCKS));
	wire logic err_sat = &err_cnt_reg;
	// Count of the closing interval including an error pulse in the same cycle as its closing strobe
	wire logic [CNT_W-1:0] final_cnt = err_cnt_reg + CNT_W'(seg_err_pulse && !err_sat);

	// Count errors over a block interval, judge against the threshold at its end [R15]
	// Saturating, so a long burst cannot wrap and read as a clean interval
	always_ff @(posedge ref_clk) begin
		if (rst || soft_reset) begin
			block_cnt_reg <= '0;
			err_cnt_reg <= '0;
			over_threshold <= 1'b0;
		end else if (interval_end) begin
			block_cnt_reg <= '0;
			err_cnt_reg <= '0;
			over_threshold <= final_cnt > CNT_W'(threshold); // [R7]
		end else begin
			if (rs_block_strobe) begin
				block_cnt_reg <= block_cnt_reg + 1'b1;
			end
			err_cnt_reg <= final_cnt;
		end
	end

endmodule

// ==== verif/apb_host.sv ====
`timescale 1ns/10ps
// Host model: an APB master that changes its lines only just after a rising edge
module apb_host
	import rx_status_pkg::*;
(
	input wire logic ref_clk,
	input wire logic pready,
	input wire logic [rx_status_pkg::DATA_W-1:0] prdata,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [rx_status_pkg::ADDR_W-1:0] paddr,
	output logic [rx_status_pkg::DATA_W-1:0] pwdata
);
	import rx_status_pkg::*;
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// One transfer; on release the address and write data are inverted so a stale value never passes
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] rd, output logic err, output bit ok);
		ok = 1'b0;
		rd = '0;
		err = 1'b0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (int i = 0; i < 16 && !ok; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) begin
				ok = 1'b1;
				rd = prdata;
				err = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	// Ask for a snapshot, then poll the bit until zero before any status read
	task automatic refresh(output bit ok);
		logic [DATA_W-1:0] rd;
		logic err;
		bit k;
		xfer(1'b1, byte_addr(IDX_UPDATE), 32'h1, rd, err, k);
		ok = 1'b0;
		for (int i = 0; i < 20 && k && !ok; i++) begin
			xfer(1'b0, byte_addr(IDX_UPDATE), '0, rd, err, k);
			if (rd[UPDATE_BIT] === 1'b0) ok = k;
		end
	endtask
endmodule

// ==== verif/receiver_status_snapshot_regs_tb_top.sv ====
`timescale 1ns/10ps
module receiver_status_snapshot_regs_tb_top;
	import rx_status_pkg::*;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, strobe, seg_err, slc, fs, co;
	logic soft_reset_out, irq, e, esl, ef, ec;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, r, d, v;
	logic [GAIN_ACC_W-1:0] acc, ea;
	int n_mismatch, total_checks, n_sr;
	integer seed = 32'he9930a94;
	// Short interval keeps each segment-error case to about a hundred cycles
	receiver_status_snapshot_regs #(.INTERVAL_BLOCKS(24'h000004)) u_dut (.ref_clk(ref_clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rs_block_strobe(strobe), .seg_err_pulse(seg_err), .slicer_err_over_threshold(slc),
		.field_sync_locked(fs), .gain_acc(acc), .cochannel_tv_detected(co),
		.soft_reset_out(soft_reset_out), .irq(irq));
	apb_host u_host (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Soft reset pulses seen on the output
	always @(posedge ref_clk) begin
		if (soft_reset_out === 1'b1) n_sr++;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// A stalled bus ends the run as a failure
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		bit ok;
		u_host.xfer(w, {2'b00, idx, 2'b00}, wd, r, e, ok);
		if (!ok) begin
			n_mismatch++;
			wrap_up();
		end
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, '0);
		check($sformatf("reg %h", idx), r, exp);
		check("slave error", {31'h0, e}, 32'h0);
	endtask
	function automatic logic [31:0] lock_exp(input logic sg, input logic sl, input logic f);
		return {28'h0, sg, 1'b0, sl, f};
	endfunction
	// Twelve blocks, n errors in every fourth, so any whole interval holds exactly n
	task automatic seg(input int n, input logic flag);
		bit ok;
		for (int b = 0; b < 12; b++) begin
			for (int c = 0; c < 8; c++) begin
				@(posedge ref_clk);
				strobe <= (c == 0);
				seg_err <= (b % 4 == 0 && c >= 1 && c <= n);
			end
		end
		u_host.refresh(ok);
		if (!ok) begin
			n_mismatch++;
			wrap_up();
		end
		rdc(IDX_LOCK, lock_exp(flag, slc, fs));
	endtask
	initial begin
		{rst, strobe, seg_err, slc, co, fs} = 6'h21;
		acc = '0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rdc(IDX_THR_LO, 32'h05);
		rdc(IDX_THR_HI, 32'h0);
		rdc(IDX_UPDATE, 32'h0);
		rdc(IDX_IRQ_MASK, 32'h0);
		d = $random(seed) | 32'hF0;
		bus(1'b1, IDX_THR_HI, d);
		rdc(IDX_THR_HI, {28'h0, d[3:0]});
		d = $random(seed);
		bus(1'b1, IDX_THR_LO, d);
		rdc(IDX_THR_LO, {24'h0, d[7:0]});
		bus(1'b1, IDX_UPDATE, 32'hFE);
		rdc(IDX_UPDATE, 32'h0);
		$display("test registers done");
		bus(1'b1, IDX_THR_LO, 32'h05);
		bus(1'b1, IDX_THR_HI, 32'h0);
		bus(1'b1, IDX_SOFT_RESET, 32'h0);
		seg(6, 1'b1);
		bus(1'b0, IDX_IRQ_STATUS, '0);
		check("status seg", {31'h0, r[EV_SEG_ERR_RISE]}, 32'h1);
		seg(5, 1'b0);
		bus(1'b1, IDX_THR_LO, 32'h02);
		seg(4, 1'b0);
		bus(1'b1, IDX_SOFT_RESET, 32'h0);
		seg(4, 1'b1);
		bus(1'b1, IDX_THR_HI, 32'h1);
		bus(1'b1, IDX_SOFT_RESET, 32'h0);
		seg(6, 1'b0);
		check("soft resets", n_sr, 3);
		$display("test threshold done");
		// Inputs move after capture; reads must keep the captured values
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			ea = (i == 3) ? 20'hFFFFF : v[19:0];
			{ec, ef, esl} = v[22:20];
			@(posedge ref_clk);
			{co, fs, slc, acc} <= {ec, ef, esl, ea};
			seg(0, 1'b0);
			@(posedge ref_clk);
			{co, fs, slc, acc} <= ~{ec, ef, esl, ea};
			rdc(IDX_ACC_LO, {24'h0, ea[7:0]});
			rdc(IDX_ACC_MID, {24'h0, ea[15:8]});
			rdc(IDX_ACC_HI, {28'h0, ea[19:16]});
			rdc(IDX_DETECT, {31'h0, ec});
			rdc(IDX_LOCK, lock_exp(1'b0, esl, ef));
		end
		$display("test snapshot done");
		bus(1'b1, IDX_IRQ_MASK, 32'h1);
		bus(1'b0, IDX_IRQ_STATUS, '0);
		seg(0, 1'b0);
		check("irq done", {31'h0, irq}, 32'h1);
		bus(1'b0, IDX_IRQ_STATUS, '0);
		check("status done", {31'h0, r[EV_CAPTURE_DONE]}, 32'h1);
		repeat (2) @(posedge ref_clk);
		check("irq cleared", {31'h0, irq}, 32'h0);
		bus(1'b1, IDX_IRQ_MASK, 32'h4);
		fs <= 1'b1;
		seg(0, 1'b0);
		check("irq masked", {31'h0, irq}, 32'h0);
		bus(1'b0, IDX_IRQ_STATUS, '0);
		fs <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check("irq lost", {31'h0, irq}, 32'h1);
		bus(1'b0, IDX_IRQ_STATUS, '0);
		check("status lost", {31'h0, r[EV_SYNC_LOST]}, 32'h1);
		$display("test interrupt done");
		bus(1'b0, 8'h30, '0);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("unmapped data", r, 32'h0);
		$display("test unmapped done");
		wrap_up();
	end
endmodule
